// >>> design/spi_fault_supervisor.v
// Serial command supervisor: CRC check, configuration, fault and thermal shutdown logic
//
// Operation
// - Checksum uses generator polynomial x^6 + x + 1 on both ends.
// - CRC mismatch drops the command, sets command fault flag, pulls fault low.
// - CRC enable configuration bit turns checking on; it resets to zero.
// - Configuration and fault register commands are never CRC checked.
// - Read-configuration returns configuration bits on serial output next frame.
// - External reference bit selects external reference when one, internal when zero.
// - Overheated channel shuts down, sets thermal fault flag, pulls fault low.
// - Shutdown channel sets its power-down bit and thermal status bit; both readable.
// - Cool channels keep running; all sixteen down puts chip to sleep.
// - Shutdown latches; recovery only when every sensor reports below recovery point.
// - Restart by clearing faults then power-down, soft reset, clear pin, power cycle.
// - Fault output released on next rising edge of chip select/load.
// - Thermal status read gives channel 15 to 0, two spare, six CRC bits.
// - Thermal protect disable bit stops over-temperature shutting channels down.
// - Fault flags stay set until fault write, clear pin, soft reset, power cycle.
// - Configuration write holds self-clearing soft reset plus three bits, all zero default.
`timescale 1ns/100ps
`include "spi_fault_regs.vh"

module spi_fault_supervisor (
   input wire clk,                        // System clock, 10 MHz
   input wire rst_n,                      // Asynchronous reset, active low
   input wire sck,                        // Serial clock pin
   input wire sdi,                        // Serial data in pin
   input wire chipSelectLoad_n,           // Chip select/load pin, active low
   output reg sdo,                        // Serial data out pin
   input wire clearInput_n,               // Clear pin, active low
   input wire [15:0] channelOverTemp,     // Per-channel sensor above shutdown point
   input wire [15:0] channelBelowRecover, // Per-channel sensor below recovery point
   output wire faultOut,                  // Open-drain fault pin data, always 0
   output reg faultOe,                    // Fault pin enable, high pulls pin low
   output wire [15:0] channelPowerdown,   // Per-channel power-down state
   output wire [15:0] channelThermalFlag, // Per-channel latched thermal shutdown
   output wire chipSleep,                 // All channels down: reference and bias off
   output wire externalReferenceSelect,   // External reference mode
   output wire thermalProtectDisable,     // Thermal shutdown disabled
   output wire crcEnable,                 // CRC checking enabled
   output wire thermalFaultFlag,          // Fault register thermal flag
   output wire clockFaultFlag,            // Fault register clock count flag
   output wire commandIntegrityFaultFlag, // Fault register command flag
   output reg cmdStrobe,                  // Pulse: other accepted command
   output reg [23:0] cmdWord              // Command and data of accepted command
);

   // ----------------------------------------------------------------
   // CRC function
   // ----------------------------------------------------------------
   function [5:0] crc6;
      input [23:0] data;
      integer i;
      reg [5:0] c;
      reg fb;
      begin
         c = 6'h00;
         for (i = 23; i >= 0; i = i - 1) begin
            fb = data[i] ^ c[5];
            c = {c[4:0], 1'b0} ^ (fb ? `CRC_POLY : 6'h00);
         end
         crc6 = c;
      end
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   reg [2:0] sckSync;
   reg [2:0] sdiSync;
   reg [2:0] csSync;
   reg [2:0] clrSync;
   reg [15:0] hotS1, hotS2, hotS3;
   reg [15:0] coolS1, coolS2, coolS3;
   reg sckLvl, sdiLvl, csLvl, clrLvl;
   reg [15:0] hotLvl, coolLvl;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sckSync <= 3'h0;
         sdiSync <= 3'h0;
         csSync <= 3'h7;
         clrSync <= 3'h7;
         hotS1 <= 16'h0000;
         hotS2 <= 16'h0000;
         hotS3 <= 16'h0000;
         coolS1 <= 16'hFFFF;
         coolS2 <= 16'hFFFF;
         coolS3 <= 16'hFFFF;
         sckLvl <= 1'b0;
         sdiLvl <= 1'b0;
         csLvl <= 1'b1;
         clrLvl <= 1'b1;
         hotLvl <= 16'h0000;
         coolLvl <= 16'hFFFF;
      end else begin
         sckSync <= {sckSync[1:0], sck};
         sdiSync <= {sdiSync[1:0], sdi};
         csSync <= {csSync[1:0], chipSelectLoad_n};
         clrSync <= {clrSync[1:0], clearInput_n};
         hotS1 <= channelOverTemp;
         hotS2 <= hotS1;
         hotS3 <= hotS2;
         coolS1 <= channelBelowRecover;
         coolS2 <= coolS1;
         coolS3 <= coolS2;
         if (sckSync[1] == sckSync[2]) sckLvl <= sckSync[2];
         if (sdiSync[1] == sdiSync[2]) sdiLvl <= sdiSync[2];
         if (csSync[1] == csSync[2]) csLvl <= csSync[2];
         if (clrSync[1] == clrSync[2]) clrLvl <= clrSync[2];
         hotLvl <= (hotS2 & hotS3) | (hotLvl & (hotS2 | hotS3));
         coolLvl <= (coolS2 & coolS3) | (coolLvl & (coolS2 | coolS3));
      end
   end

   // ----------------------------------------------------------------
   // Pin edges
   // ----------------------------------------------------------------
   // Reset values equal the idle pin levels, so no false edge follows reset
   reg sckPrev, csPrev;
   wire sckRise = sckLvl & ~sckPrev;
   wire sckFall = ~sckLvl & sckPrev;
   wire csFall = ~csLvl & csPrev;
   wire csRise = csLvl & ~csPrev;

   // ----------------------------------------------------------------
   // Frame capture
   // ----------------------------------------------------------------
   reg [31:0] inShift;
   reg [31:0] outShift;
   reg [4:0] bitMod;
   // Set once 32 bits have arrived, which tells a 24-bit frame from a 32-bit one
   reg bitWrapped;
   reg inFrame;

   wire shortFrame = (bitMod == `SHORT_FRAME_BITS) & ~bitWrapped;
   wire longFrame = (bitMod == 5'h00) & bitWrapped;
   // Longer frames keep only their last 32 bits
   wire [23:0] frameWord = longFrame ? inShift[31:8] : inShift[23:0];
   wire [7:0] frameCmd = frameWord[23:16];
   wire [15:0] frameData = frameWord[15:0];
   wire crcExempt = (frameCmd == `CMD_WRITE_CONFIG) | (frameCmd == `CMD_WRITE_FAULT) |
                    (frameCmd == `CMD_READ_CONFIG) | (frameCmd == `CMD_READ_FAULT);
   wire crcMatch = longFrame & (crc6(frameWord) == inShift[5:0]);

   // ----------------------------------------------------------------
   // Command checks
   // ----------------------------------------------------------------
   reg [2:0] settings;
   reg [2:0] faults;
   reg [15:0] powerdown;
   reg [15:0] thermalLatch;

   wire frameDone = csRise & inFrame;
   wire frameOk = shortFrame | longFrame;
   wire crcBad = frameDone & frameOk & settings[`CFG_CRC_ENABLE_BIT] & ~crcExempt &
                 ~crcMatch;
   wire clockBad = frameDone & ~frameOk;
   wire execute = frameDone & frameOk & ~crcBad;

   // Recovery is allowed only once every sensor reads below its recovery point
   wire allCool = &coolLvl;
   wire softReset = execute & (frameCmd == `CMD_WRITE_CONFIG) &
                    frameData[`CFG_SOFT_RESET_BIT];
   wire globalClear = softReset | ~clrLvl;
   wire [15:0] newHot = hotLvl & ~thermalLatch &
                        {16{~settings[`CFG_THERMAL_DISABLE_BIT]}};
   wire thermalEvent = |newHot;

   // ----------------------------------------------------------------
   // Read-back word for the next frame
   // ----------------------------------------------------------------
   reg [15:0] readData;
   always @* begin
      case (frameCmd)
         `CMD_READ_CONFIG: readData = {13'h0000, settings};
         `CMD_READ_FAULT: readData = {13'h0000, faults};
         `CMD_READ_POWERDOWN: readData = powerdown;
         `CMD_READ_THERMAL: readData = thermalLatch;
         default: readData = 16'h0000;
      endcase
   end
   wire [23:0] replyHead = {frameCmd, readData};

   // ----------------------------------------------------------------
   // Serial shift engine
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sckPrev <= 1'b0;
         csPrev <= 1'b1;
         inShift <= 32'h0000_0000;
         outShift <= 32'h0000_0000;
         bitMod <= 5'h00;
         bitWrapped <= 1'b0;
         inFrame <= 1'b0;
         sdo <= 1'b0;
         cmdStrobe <= 1'b0;
         cmdWord <= 24'h00_0000;
      end else begin
         sckPrev <= sckLvl;
         csPrev <= csLvl;
         cmdStrobe <= 1'b0;
         if (csFall) begin
            inFrame <= 1'b1;
            bitMod <= 5'h00;
            bitWrapped <= 1'b0;
            sdo <= outShift[31];
         end else if (!csLvl && inFrame) begin
            if (sckRise) begin
               inShift <= {inShift[30:0], sdiLvl};
               bitMod <= bitMod + 5'h01;
               if (bitMod == 5'h1F) bitWrapped <= 1'b1;
            end
            if (sckFall) begin
               outShift <= {outShift[30:0], 1'b0};
               sdo <= outShift[30];
            end
         end
         if (frameDone) begin
            inFrame <= 1'b0;
            // Reply stays zero unless this frame executed; other executed commands echo their command byte with zero data
            outShift <= execute ? {replyHead, 2'b00, crc6(replyHead)} : 32'h0000_0000;
            if (execute) begin
               cmdWord <= frameWord;
               cmdStrobe <= ~crcExempt & (frameCmd != `CMD_WRITE_POWERDOWN) &
                            (frameCmd != `CMD_READ_POWERDOWN) &
                            (frameCmd != `CMD_READ_THERMAL);
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Configuration, fault, power-down and thermal registers
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         settings <= `CFG_RESET;
         faults <= `FLT_RESET;
         powerdown <= `PD_RESET;
         thermalLatch <= `TSD_RESET;
      end else begin
         if (globalClear) begin
            settings <= `CFG_RESET;
            // Events in the clearing cycle still set their flags
            faults <= `FLT_RESET | {thermalEvent, clockBad, crcBad};
            // Hot channels keep their latch until all sensors have cooled
            thermalLatch <= (allCool ? 16'h0000 : thermalLatch) | newHot;
            powerdown <= (allCool ? 16'h0000 : thermalLatch) | newHot;
         end else begin
            if (execute && frameCmd == `CMD_WRITE_CONFIG)
               settings <= frameData[2:0];
            if (execute && frameCmd == `CMD_WRITE_FAULT)
               faults <= frameData[2:0] | {thermalEvent, clockBad, crcBad};
            else
               faults <= faults | {thermalEvent, clockBad, crcBad};
            // Fault flag cleared while cool releases the thermal latch
            if (execute && frameCmd == `CMD_WRITE_FAULT && allCool &&
                !frameData[`FLT_THERMAL_BIT])
               thermalLatch <= newHot;
            else
               thermalLatch <= thermalLatch | newHot;
            if (execute && frameCmd == `CMD_WRITE_POWERDOWN)
               powerdown <= frameData | thermalLatch | newHot;
            else
               powerdown <= powerdown | newHot;
         end
      end
   end

   // ----------------------------------------------------------------
   // Fault pin
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         faultOe <= 1'b0;
      end else if (crcBad | clockBad | thermalEvent) begin
         // A new event wins over the release edge
         faultOe <= 1'b1;
      end else if (csRise) begin
         faultOe <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign faultOut = 1'b0;
   assign channelPowerdown = powerdown;
   assign channelThermalFlag = thermalLatch;
   assign chipSleep = &powerdown;
   assign externalReferenceSelect = settings[`CFG_EXTERNAL_REFERENCE_SELECT_BIT];
   assign thermalProtectDisable = settings[`CFG_THERMAL_DISABLE_BIT];
   assign crcEnable = settings[`CFG_CRC_ENABLE_BIT];
   assign thermalFaultFlag = faults[`FLT_THERMAL_BIT];
   assign clockFaultFlag = faults[`FLT_CLOCK_BIT];
   assign commandIntegrityFaultFlag = faults[`FLT_COMMAND_BIT];

endmodule

// >>> design/spi_fault_regs.vh
// Command codes, field positions and constants of the serial fault supervisor
`ifndef SPI_FAULT_REGS_VH
`define SPI_FAULT_REGS_VH

`define CMD_WRITE_CONFIG 8'h70
`define CMD_WRITE_POWERDOWN 8'h71
`define CMD_WRITE_FAULT 8'h76
`define CMD_READ_CONFIG 8'hF0
`define CMD_READ_POWERDOWN 8'hF1
`define CMD_READ_FAULT 8'hF6
`define CMD_READ_THERMAL 8'hF7

`define CFG_SOFT_RESET_BIT 15
`define CFG_THERMAL_DISABLE_BIT 2
`define CFG_EXTERNAL_REFERENCE_SELECT_BIT 1
`define CFG_CRC_ENABLE_BIT 0
`define CFG_RESET 3'h0

`define FLT_THERMAL_BIT 2
`define FLT_CLOCK_BIT 1
`define FLT_COMMAND_BIT 0
`define FLT_RESET 3'h0

`define PD_RESET 16'h0000
`define TSD_RESET 16'h0000

`define CRC_POLY 6'h03
`define SHORT_FRAME_BITS 5'h18
`define LONG_FRAME_BITS 32

`endif

// >>> tb/spi_fault_supervisor_sva.sv
// Concurrent checks on the serial fault supervisor ports
`timescale 1ns/100ps
module spi_fault_supervisor_sva (
   input wire clk, // System clock
   input wire rst_n, // Reset, active low
   input wire chipSelectLoad_n, // Frame pin
   input wire clearInput_n, // Clear pin
   input wire [15:0] channelBelowRecover, // Cool sensors
   input wire faultOut, // Fault pin data
   input wire faultOe, // Fault pin enable
   input wire [15:0] channelPowerdown, // Power-down bits
   input wire [15:0] channelThermalFlag, // Latched shutdown bits
   input wire chipSleep, // Chip asleep
   input wire externalReferenceSelect, // Config bit
   input wire thermalProtectDisable, // Config bit
   input wire crcEnable, // Config bit
   input wire thermalFaultFlag, // Fault bit
   input wire clockFaultFlag, // Fault bit
   input wire commandIntegrityFaultFlag // Fault bit
);
   logic csPrev;
   logic [3:0] csSince;
   logic [3:0] clrSince;
   logic [2:0] hotCnt;
   // Ages since the frame pin rose, since clear was low, and of a hot sensor
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         csPrev <= 1'b1;
         csSince <= 4'hF;
         clrSince <= 4'hF;
         hotCnt <= 3'h0;
      end else begin
         csPrev <= chipSelectLoad_n;
         csSince <= (chipSelectLoad_n && !csPrev) ? 4'h0 : csSince + {3'h0, csSince != 4'hF};
         clrSince <= !clearInput_n ? 4'h0 : clrSince + {3'h0, clrSince != 4'hF};
         hotCnt <= (&channelBelowRecover) ? 3'h0 : hotCnt + {2'h0, hotCnt != 3'h7};
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_data_low; faultOut == 1'b0; endproperty
   a_data_low: assert property (p_data_low) else $error("fault data not low");
   property p_sleep; chipSleep == (&channelPowerdown); endproperty
   a_sleep: assert property (p_sleep) else $error("sleep mismatch");
   property p_new_tsd;
      |(channelThermalFlag & ~$past(channelThermalFlag)) |->
         ((channelThermalFlag & ~$past(channelThermalFlag) & ~channelPowerdown) == 16'h0000)
         && thermalFaultFlag;
   endproperty
   a_new_tsd: assert property (p_new_tsd) else $error("shutdown bits incomplete");
   property p_dis; thermalProtectDisable && $past(thermalProtectDisable) |->
      (channelThermalFlag & ~$past(channelThermalFlag)) == 16'h0000; endproperty
   a_dis: assert property (p_dis) else $error("shutdown while disabled");
   property p_latch; hotCnt == 3'h7 |->
      ($past(channelThermalFlag) & ~channelThermalFlag) == 16'h0000; endproperty
   a_latch: assert property (p_latch) else $error("shutdown left while hot");
   property p_release; $fell(faultOe) |-> csSince <= 4'h8; endproperty
   a_release: assert property (p_release) else $error("fault pin freed early");
   property p_cfg_reset; $rose(rst_n) |->
      !crcEnable && !externalReferenceSelect && !thermalProtectDisable; endproperty
   a_cfg_reset: assert property (p_cfg_reset) else $error("config not cleared");
   property p_hold; $fell(thermalFaultFlag) || $fell(clockFaultFlag) ||
      $fell(commandIntegrityFaultFlag) |-> csSince <= 4'h8 || clrSince <= 4'h8; endproperty
   a_hold: assert property (p_hold) else $error("fault flag dropped");
   c_fault: cover property ($rose(faultOe));
   c_sleep: cover property ($rose(chipSleep));
   c_tsd: cover property (|(channelThermalFlag & ~$past(channelThermalFlag)));
endmodule
bind spi_fault_supervisor spi_fault_supervisor_sva spi_fault_supervisor_sva_inst (
   .clk(clk), .rst_n(rst_n), .chipSelectLoad_n(chipSelectLoad_n), .clearInput_n(clearInput_n),
   .channelBelowRecover(channelBelowRecover), .faultOut(faultOut), .faultOe(faultOe),
   .channelPowerdown(channelPowerdown), .channelThermalFlag(channelThermalFlag),
   .chipSleep(chipSleep), .externalReferenceSelect(externalReferenceSelect),
   .thermalProtectDisable(thermalProtectDisable), .crcEnable(crcEnable),
   .thermalFaultFlag(thermalFaultFlag), .clockFaultFlag(clockFaultFlag),
   .commandIntegrityFaultFlag(commandIntegrityFaultFlag));

// >>> tb/spi_host_model.sv
// Serial host that frames commands, clocking bits every 800 ns
`timescale 1ns/100ps
module spi_host_model (
   input wire clk, // Bench clock, lines change on its falling edge
   output logic sck, // Serial clock, still between frames
   output logic sdi, // Data to the supervisor
   output logic csN, // Chip select/load, active low
   input wire sdo // Data from the supervisor
);
   initial begin
      sck = 1'b0;
      sdi = 1'b0;
      csN = 1'b1;
   end
   // Sends n bits from w[31] down, collects the reply in r
   task automatic xfer(input int n, input logic [31:0] w, output logic [31:0] r);
      r = 32'h0;
      @(negedge clk) csN = 1'b0;
      repeat (8) @(negedge clk);
      for (int i = 0; i < n; i++) begin
         sdi = w[31 - i];
         repeat (4) @(negedge clk);
         sck = 1'b1;
         repeat (4) @(negedge clk);
         r = {r[30:0], sdo};
         sck = 1'b0;
      end
      repeat (4) @(negedge clk);
      csN = 1'b1;
      sdi = ~sdi;
      repeat (12) @(negedge clk);
   endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the serial fault supervisor
`timescale 1ns/100ps
`include "spi_fault_regs.vh"
module tb_top;
   logic clk, rst_n, clearInput_n, sck, sdi, csN, sdo, faultOut, faultOe, chipSleep;
   logic extRef, tsdDis, crcEn, thermal_fault_flag, ckf, cf, cmdStrobe;
   logic [15:0] overTemp, belowRecover, powerdown, thermalFlag, d, m;
   logic [23:0] cmdWord;
   logic [31:0] rep, seed;
   int err_total, total_checks, strobes;
   int cycles = 0;
   spi_fault_supervisor spi_fault_supervisor_inst (.clk(clk), .rst_n(rst_n), .sck(sck),
      .sdi(sdi), .chipSelectLoad_n(csN), .sdo(sdo), .clearInput_n(clearInput_n),
      .channelOverTemp(overTemp), .channelBelowRecover(belowRecover), .faultOut(faultOut),
      .faultOe(faultOe), .channelPowerdown(powerdown), .channelThermalFlag(thermalFlag),
      .chipSleep(chipSleep), .externalReferenceSelect(extRef), .thermalProtectDisable(tsdDis),
      .crcEnable(crcEn), .thermalFaultFlag(thermal_fault_flag), .clockFaultFlag(ckf),
      .commandIntegrityFaultFlag(cf), .cmdStrobe(cmdStrobe), .cmdWord(cmdWord));
   spi_host_model spi_host_model_inst (.clk(clk), .sck(sck), .sdi(sdi), .csN(csN), .sdo(sdo));
   function automatic logic [5:0] crc6(input logic [23:0] v);
      logic [5:0] c;
      c = 6'h00;
      for (int i = 23; i >= 0; i--) c = {c[4:0], 1'b0} ^ ((c[5] ^ v[i]) ? `CRC_POLY : 6'h00);
      return c;
   endfunction
   function automatic logic [31:0] frm(input logic [7:0] c, input logic [15:0] v);
      return {c, v, 2'b00, crc6({c, v})};
   endfunction
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic go(input int n, input logic [31:0] w);
      spi_host_model_inst.xfer(n, w, rep);
   endtask
   task automatic rd(input logic [7:0] c, input logic [15:0] v);
      go(32, frm(c, 16'h0000));
      go(32, frm(c, 16'h0000));
      chk("reply", frm(c, v), rep);
   endtask
   task automatic heat(input logic [15:0] hot, input logic [15:0] cool);
      overTemp = hot;
      belowRecover = cool;
      repeat (10) @(negedge clk);
   endtask
   task end_of_test;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Counts accepted-command pulses, each standing one cycle
   always @(negedge clk)
      if (cmdStrobe === 1'b1) strobes++;
   // Cuts a hang short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         err_total++;
         end_of_test;
      end
   end
   initial begin
      {rst_n, clearInput_n, overTemp, belowRecover, seed} = {2'b01, 32'h0000FFFF, 32'h53};
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      repeat (6) @(negedge clk);
      chk("cfg", 0, {crcEn, extRef, tsdDis, thermal_fault_flag, ckf, cf, faultOe});
      rd(`CMD_READ_CONFIG, 16'h0000);
      go(24, {`CMD_WRITE_CONFIG, 16'h0003, 8'h00});
      chk("crcRef", 3, {crcEn, extRef});
      go(32, frm(`CMD_READ_CONFIG, 16'h0000) ^ 32'h1);
      chk("cmdFlt", 0, cf);
      go(32, frm(`CMD_READ_CONFIG, 16'h0000));
      chk("reply", frm(`CMD_READ_CONFIG, 16'h0003), rep);
      for (int i = 0; i < 3; i++) begin
         seed = xs(seed);
         d = seed[15:0];
         go(32, frm(`CMD_WRITE_POWERDOWN, d));
         chk("pd", {d, &d}, {powerdown, chipSleep});
         chk("cmdWord", {`CMD_WRITE_POWERDOWN, d}, cmdWord);
         rd(`CMD_READ_POWERDOWN, d);
         go(32, frm({4'h0, seed[19:16]}, ~d));
         chk("other", {4'h0, seed[19:16], ~d, 8'(i + 1)}, {cmdWord, strobes[7:0]});
      end
      go(32, frm(`CMD_WRITE_POWERDOWN, ~d) ^ 32'h4);
      chk("badCrc", {d, 2'b11}, {powerdown, cf, faultOe});
      go(24, {`CMD_WRITE_POWERDOWN, ~d, 8'h00});
      chk("short", d, powerdown);
      go(20, frm(`CMD_WRITE_POWERDOWN, ~d));
      chk("clkFlt", {d, 1'b1}, {powerdown, ckf});
      go(32, frm(8'h05, d) ^ 32'h100);
      chk("badOther", {8'h03, 2'b11}, {strobes[7:0], cf, faultOe});
      go(32, frm(`CMD_READ_FAULT, 16'h0000));
      chk("release", 0, faultOe);
      go(32, frm(`CMD_READ_FAULT, 16'h0000));
      chk("reply", frm(`CMD_READ_FAULT, 16'h0003), rep);
      go(32, frm(`CMD_WRITE_FAULT, 16'h0000));
      go(32, frm(`CMD_WRITE_POWERDOWN, 16'h0000));
      chk("cleared", 0, {thermal_fault_flag, ckf, cf, powerdown});
      m = 16'h0001 << seed[19:16];
      heat(m, ~m);
      chk("hotBits", {m, m}, {thermalFlag, powerdown});
      chk("hotPin", 3'b110, {thermal_fault_flag, faultOe, chipSleep});
      rd(`CMD_READ_THERMAL, m);
      heat(16'h0000, ~m);
      go(32, frm(`CMD_WRITE_FAULT, 16'h0000));
      go(32, frm(`CMD_WRITE_POWERDOWN, 16'h0000));
      chk("latched", {m, m}, {thermalFlag, powerdown});
      heat(16'h0000, 16'hFFFF);
      go(32, frm(`CMD_WRITE_FAULT, 16'h0000));
      go(32, frm(`CMD_WRITE_POWERDOWN, 16'h0000));
      chk("recovered", 0, {thermalFlag, powerdown});
      heat(16'hFFFF, 16'h0000);
      chk("sleep", 1, chipSleep);
      heat(16'h0000, 16'hFFFF);
      clearInput_n = 1'b0;
      repeat (6) @(negedge clk);
      clearInput_n = 1'b1;
      repeat (6) @(negedge clk);
      chk("clrPin", 0, {crcEn, extRef, thermal_fault_flag, thermalFlag, powerdown});
      go(24, {`CMD_WRITE_CONFIG, 16'h0004, 8'h00});
      heat(m, ~m);
      chk("tsdDis", 3'b100, {tsdDis, thermal_fault_flag, |thermalFlag});
      go(24, {`CMD_WRITE_CONFIG, 16'h8000, 8'h00});
      chk("softRst", {2'b01, m}, {tsdDis, thermal_fault_flag, thermalFlag});
      end_of_test;
   end
endmodule
